// file: verilog/lpa_link_partner_ability.sv
// Link partner ability capture: base and next page views at one address.
// Assumes the auto-negotiation engine on the same clock delivers each
// received link code word as a one-cycle strobe with the word beside it.
//
// How it works
// - Address 0x05 reads the received partner ability word; resets to zero.
// - With next pages supported, next page replaces base view after completion.
// - Bit 15 shows partner request for more pages in both views.
// - Bit 14 is the partner acknowledge, taken only from received bursts.
// - Base view bit 13 shows partner remote fault.
// - Base view bits 11 and 10 show asymmetric and symmetric pause.
// - Base view bits 9 to 5 show partner technology abilities.
// - Base view bits 4 to 0 hold the received selector, reset zero.
// - Base view bit 12 always reads zero.
// - Next view bit 13 marks message page versus unformatted page.
// - Next view bit 12 shows partner can comply with message.
// - Next view bit 11 is the received toggle bit.
// - Next view bits 10 to 0 hold the received code, reset zero.
// - Expansion page received flag clears on read.
//
// Our own choice: the address-and-strobe port.
`include "lpa_defines.svh"

module lpa_link_partner_ability
    import lpa_pkg::*;
#(
    parameter int ADDR_W = 5
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Management register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rd_data,
    // Auto-negotiation engine
    input wire logic i_page_valid,
    input wire logic [15:0] i_page_word,
    input wire logic i_an_complete,
    input wire logic i_np_enable,
    input wire logic i_an_restart,
    // Status
    output logic o_next_page_view,
    output logic o_page_received
);

    generate
        if (ADDR_W < 3)
        begin : g_bad_addr
            $error("lpa_link_partner_ability: ADDR_W too small");
        end
    endgenerate

    lpa_word_t base_q;
    lpa_word_t next_q;
    lpa_word_t shown;
    logic base_load;
    logic next_load;
    logic page_rx;
    logic partner_an_able;
    logic hit_partner;
    logic hit_expansion;
    lpa_view_e view_r;
    lpa_view_e view_nxt;
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;
    logic view_out_r;
    logic page_out_r;

    assign hit_partner = (i_addr == ADDR_W'(`LPA_ADDR_PARTNER));
    assign hit_expansion = (i_addr == ADDR_W'(`LPA_ADDR_EXPANSION));

    // Pages seen before completion are base pages, later ones next pages only while next pages are enabled
    assign base_load = i_page_valid && !i_an_complete;
    assign next_load = i_page_valid && i_an_complete && i_np_enable;

    // Word taken whole from the bursts; the write port feeds nothing here
    lpa_word_reg #(
        .W(16)
    ) u_base (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_load(base_load),
        .i_clear(i_an_restart),
        .i_d(i_page_word),
        .o_q(base_q)
    );

    lpa_word_reg #(
        .W(16)
    ) u_next (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_load(next_load),
        .i_clear(i_an_restart),
        .i_d(i_page_word),
        .o_q(next_q)
    );

    // A page arriving with the read still sets the flag
    lpa_cor_flag u_page_rx (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_set(i_page_valid),
        .i_clr(i_rd && hit_expansion),
        .o_q(page_rx)
    );

    lpa_cor_flag u_an_able (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_set(base_load),
        .i_clr(i_an_restart),
        .o_q(partner_an_able)
    );

    // View selection
    always_comb
    begin
        view_nxt = view_r;
        case (view_r)
            LPA_VIEW_BASE:
            begin
                if (next_load)
                begin
                    view_nxt = LPA_VIEW_NEXT;
                end
            end
            LPA_VIEW_NEXT:
            begin
                if (i_an_restart || !i_np_enable)
                begin
                    view_nxt = LPA_VIEW_BASE;
                end
            end
            default:
            begin
                view_nxt = LPA_VIEW_BASE;
            end
        endcase
    end

    // Base view masks the reserved bit; the next view reuses it
    always_comb
    begin
        if (view_r == LPA_VIEW_NEXT)
        begin
            shown = next_q;
        end
        else
        begin
            shown = base_q & ~(`LPA_BASE_RSVD_MASK);
        end
    end

    // Read data lives one cycle only; writes never reach storage
    always_comb
    begin
        rd_data_nxt = 16'h0000;
        if (i_rd && hit_partner)
        begin
            rd_data_nxt = shown;
        end
        else if (i_rd && hit_expansion)
        begin
            rd_data_nxt[`LPA_EXP_BIT_PARTNER_NP] = base_q[`LPA_BIT_MORE_PAGES];
            rd_data_nxt[`LPA_EXP_BIT_PAGE_RX] = page_rx;
            rd_data_nxt[`LPA_EXP_BIT_PARTNER_AN] = partner_an_able;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            view_r <= LPA_VIEW_BASE;
            rd_data_r <= `LPA_WORD_RESET;
            view_out_r <= 1'b0;
            page_out_r <= 1'b0;
        end
        else
        begin
            view_r <= view_nxt;
            rd_data_r <= rd_data_nxt;
            view_out_r <= (view_nxt == LPA_VIEW_NEXT);
            page_out_r <= page_rx;
        end
    end

    assign o_rd_data = rd_data_r;
    assign o_next_page_view = view_out_r;
    assign o_page_received = page_out_r;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_base_capture: assert property (
        base_load && !i_an_restart |=> base_q == $past(i_page_word))
        else $error("base page not captured");

    a_view_switch: assert property (
        next_load && !i_an_restart |=> o_next_page_view)
        else $error("next page view not entered");

    a_more_pages: assert property (
        i_rd && hit_partner
        |=> o_rd_data[`LPA_BIT_MORE_PAGES] ==
            $past(shown[`LPA_BIT_MORE_PAGES]))
        else $error("more pages bit wrong");

    a_ack_source: assert property (
        next_load && !i_an_restart
        |=> next_q[`LPA_BIT_ACK] == $past(i_page_word[`LPA_BIT_ACK]))
        else $error("acknowledge bit not from burst");

    a_base_fields: assert property (
        i_rd && hit_partner && view_r == LPA_VIEW_BASE
        |=> o_rd_data == ($past(base_q) & ~(`LPA_BASE_RSVD_MASK)))
        else $error("base view fields wrong");

    a_reserved_zero: assert property (
        i_rd && hit_partner && view_r == LPA_VIEW_BASE
        |=> !o_rd_data[`LPA_BIT_RESERVED])
        else $error("reserved bit read nonzero");

    a_next_fields: assert property (
        i_rd && hit_partner && view_r == LPA_VIEW_NEXT
        |=> o_rd_data == $past(next_q))
        else $error("next view fields wrong");

    a_page_clear: assert property (
        i_rd && hit_expansion && !i_page_valid |=> !page_rx ##1 !o_page_received)
        else $error("page received not cleared on read");

    a_page_set: assert property (
        i_page_valid |=> page_rx)
        else $error("page received not set");

    a_write_ignored: assert property (
        i_wr && !i_page_valid && !i_an_restart
        |=> $stable(base_q) && $stable(next_q))
        else $error("write changed partner word");

    a_read_one_cycle: assert property (
        !i_rd |=> o_rd_data == 16'h0000)
        else $error("read data outside read cycle");

    a_exp_more_pages: assert property (
        i_rd && hit_expansion
        |=> o_rd_data[`LPA_EXP_BIT_PARTNER_NP] ==
            $past(base_q[`LPA_BIT_MORE_PAGES]))
        else $error("partner next page able bit wrong");

    a_restart_clear: assert property (
        i_an_restart && !i_page_valid
        |=> base_q == `LPA_WORD_RESET && next_q == `LPA_WORD_RESET)
        else $error("restart left a stored word");

    a_view_return: assert property (
        view_r == LPA_VIEW_NEXT && (i_an_restart || !i_np_enable)
        |=> !o_next_page_view)
        else $error("next page view held too long");

    a_unmapped_zero: assert property (
        i_rd && !hit_partner && !hit_expansion
        |=> o_rd_data == 16'h0000)
        else $error("unmapped address read nonzero");

    // Stored words move only on a page or a restart
    a_base_kept: assert property (
        i_page_valid && i_an_complete && !i_an_restart |=> $stable(base_q))
        else $error("late page overwrote base word");

    a_next_unused: assert property (
        i_page_valid && i_an_complete && !i_np_enable && !i_an_restart
        |=> $stable(next_q))
        else $error("next page stored while unsupported");

    a_base_held: assert property (
        !base_load && !i_an_restart |=> $stable(base_q))
        else $error("base word changed without a page");

    a_next_held: assert property (
        !next_load && !i_an_restart |=> $stable(next_q))
        else $error("next page word changed without a page");

    a_flag_set_wins: assert property (
        i_page_valid && i_rd && hit_expansion |=> page_rx)
        else $error("read clear beat a new page");

    a_page_hold: assert property (
        !i_page_valid && !(i_rd && hit_expansion) |=> $stable(page_rx))
        else $error("page received flag moved on its own");

    c_base_page: cover property (base_load ##[1:6] i_rd && hit_partner);
    c_next_view: cover property (next_load ##[2:6] i_rd && hit_partner);
    c_set_and_clear: cover property (i_page_valid && i_rd && hit_expansion);
    c_view_return: cover property (view_r == LPA_VIEW_NEXT ##1
        view_r == LPA_VIEW_BASE);
    c_restart: cover property (i_an_restart && partner_an_able);

endmodule : lpa_link_partner_ability

// file: verilog/lpa_defines.svh
// Constants for the link partner ability capture block.
// Assumes a 5-bit management address and 16-bit management data.
`ifndef LPA_DEFINES_SVH
`define LPA_DEFINES_SVH

`define LPA_ADDR_PARTNER 5'h05
`define LPA_ADDR_EXPANSION 5'h06
`define LPA_WORD_RESET 16'h0000
`define LPA_BIT_MORE_PAGES 15
`define LPA_BIT_ACK 14
`define LPA_BIT_REMOTE_FAULT 13
`define LPA_BIT_MESSAGE_PAGE 13
`define LPA_BIT_RESERVED 12
`define LPA_BIT_CAN_COMPLY 12
`define LPA_BIT_ASYM_PAUSE 11
`define LPA_BIT_TOGGLE 11
`define LPA_BIT_SYM_PAUSE 10
`define LPA_BASE_RSVD_MASK 16'h1000
`define LPA_EXP_BIT_PARTNER_NP 3
`define LPA_EXP_BIT_PAGE_RX 1
`define LPA_EXP_BIT_PARTNER_AN 0

`endif

// file: verilog/lpa_pkg.sv
// Types shared by the link partner ability capture block.
// Assumes lpa_defines.svh carries all numeric constants.
package lpa_pkg;

    typedef enum logic {
        LPA_VIEW_BASE,
        LPA_VIEW_NEXT
    } lpa_view_e;

    typedef logic [15:0] lpa_word_t;

endpackage : lpa_pkg

// file: verilog/lpa_word_reg.sv
// Capture register for one received link code word.
// Assumes load and clear come from logic on the same clock.
module lpa_word_reg
    import lpa_pkg::*;
#(
    parameter int W = 16
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_load,
    input wire logic i_clear,
    input wire logic [W-1:0] i_d,
    // Stored word
    output logic [W-1:0] o_q
);

    generate
        if (W < 1)
        begin : g_bad_width
            $error("lpa_word_reg: W must be at least 1");
        end
    endgenerate

    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        q_nxt = q_r;
        if (i_load)
        begin
            q_nxt = i_d;
        end
        else if (i_clear)
        begin
            q_nxt = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q_r <= '0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;

endmodule : lpa_word_reg

// file: verilog/lpa_cor_flag.sv
// Sticky flag set by hardware, cleared by a read; a set beats a clear.
// Assumes both inputs are single-cycle pulses on the same clock.
module lpa_cor_flag
    import lpa_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Events
    input wire logic i_set,
    input wire logic i_clr,
    // Flag
    output logic o_q
);

    logic q_r;
    logic q_nxt;

    always_comb
    begin
        q_nxt = q_r;
        if (i_set)
        begin
            q_nxt = 1'b1;
        end
        else if (i_clr)
        begin
            q_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            q_r <= 1'b0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;

endmodule : lpa_cor_flag

// file: sim/lpa_partner_model.sv
// Remote link partner model: hands received link code words to the block.
// Assumes the bench asks for a page with a one-cycle send pulse.
module lpa_partner_model
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Requests from the bench
    input wire logic i_send,
    input wire logic i_slow,
    input wire logic [15:0] i_word,
    // Page strobe toward the block
    output logic o_page_valid,
    output logic [15:0] o_page_word
);
    timeunit 1ns;
    timeprecision 1ps;

    logic hold_r;
    logic [15:0] word_r;

    // Idle word is inverted each cycle so a stale value never looks valid
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            hold_r <= 1'b0;
            word_r <= 16'h0000;
            o_page_valid <= 1'b0;
            o_page_word <= 16'h0000;
        end
        else if (i_send && !i_slow)
        begin
            o_page_valid <= 1'b1;
            o_page_word <= i_word;
        end
        else if (i_send)
        begin
            hold_r <= 1'b1;
            word_r <= i_word;
            o_page_valid <= 1'b0;
            o_page_word <= ~o_page_word;
        end
        else if (hold_r)
        begin
            hold_r <= 1'b0;
            o_page_valid <= 1'b1;
            o_page_word <= word_r;
        end
        else
        begin
            o_page_valid <= 1'b0;
            o_page_word <= ~o_page_word;
        end
    end
endmodule : lpa_partner_model

// file: sim/lpa_link_partner_ability_tb_top.sv
// Self-checking bench for the link partner ability capture block.
// Assumes a single 100 MHz clock and the partner model beside it.
module lpa_link_partner_ability_tb_top
    import lpa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [4:0] i_addr = 5'h00;
    lpa_word_t i_wr_data = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_an_complete = 1'b0;
    logic i_np_enable = 1'b0;
    logic i_an_restart = 1'b0;
    logic send = 1'b0;
    logic slow = 1'b0;
    logic rd_seen = 1'b0;
    lpa_word_t word = 16'h0000;
    lpa_word_t o_rd_data;
    lpa_word_t page_word;
    logic page_valid;
    logic o_next_page_view;
    logic o_page_received;
    int miscompares = 0;
    int checks = 0;
    lpa_word_t exp_q[$];
    lpa_word_t lfsr_r = 16'h41dc;

    lpa_partner_model partner (.i_ref_clk, .i_rst_b, .i_send(send),
        .i_slow(slow), .i_word(word), .o_page_valid(page_valid),
        .o_page_word(page_word));

    lpa_link_partner_ability #(.ADDR_W(5)) uut (.i_ref_clk, .i_rst_b,
        .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
        .i_page_valid(page_valid), .i_page_word(page_word), .i_an_complete,
        .i_np_enable, .i_an_restart, .o_next_page_view, .o_page_received);

    initial
    begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    function automatic lpa_word_t next_rand(input lpa_word_t s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand

    task automatic check(input lpa_word_t seen, input lpa_word_t exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic rd(input logic [4:0] a, input lpa_word_t e);
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_ref_clk);
    endtask : rd

    task automatic wr(input logic [4:0] a, input lpa_word_t d);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_ref_clk);
    endtask : wr

    task automatic idle(input int n);
        i_rd <= 1'b0;
        i_wr <= 1'b0;
        repeat (n) @(posedge i_ref_clk);
    endtask : idle

    // Pace is random so both prompt and late strobes are seen
    task automatic page(input lpa_word_t w, input logic view);
        i_rd <= 1'b0;
        i_wr <= 1'b0;
        send <= 1'b1;
        word <= w;
        slow <= lfsr_r[0];
        @(posedge i_ref_clk);
        send <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        check(16'(o_page_received), 16'h0001);
        check(16'(o_next_page_view), 16'(view));
        @(posedge i_ref_clk);
    endtask : page

    // Read data stands only in the cycle after the strobe
    always @(posedge i_ref_clk)
        rd_seen <= i_rd;

    always @(negedge i_ref_clk)
        if (rd_seen)
            check(o_rd_data, exp_q.pop_front());

    initial
    begin
        lpa_word_t w;
        lpa_word_t b;
        repeat (20) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        @(posedge i_ref_clk);
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            lfsr_r = next_rand(lfsr_r);
            b = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : lfsr_r;
            page(b, 1'b0);
            // Software keeps clear of the acknowledge bit
            wr(5'h05, ~b & 16'hbfff);
            rd(5'h05, b & 16'hefff);
            rd(5'h06, {12'h000, b[15], 3'b011});
            rd(5'h06, {12'h000, b[15], 3'b001});
            rd(5'h1f, 16'h0000);
            idle(1);
        end
        i_an_complete <= 1'b1;
        i_np_enable <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            lfsr_r = next_rand(lfsr_r);
            w = {lfsr_r[15:14], 2'(i), lfsr_r[11:0]};
            page(w, 1'b1);
            rd(5'h05, w);
            wr(5'h05, ~w & 16'hbfff);
            rd(5'h05, w);
            idle(1);
        end
        i_np_enable <= 1'b0;
        idle(2);
        rd(5'h05, b & 16'hefff);
        page(~b, 1'b0);
        rd(5'h05, b & 16'hefff);
        i_an_restart <= 1'b1;
        i_an_complete <= 1'b0;
        idle(1);
        i_an_restart <= 1'b0;
        idle(1);
        rd(5'h05, 16'h0000);
        // A page landing on the clearing read must keep the flag set
        send <= 1'b1;
        slow <= 1'b0;
        word <= 16'h8001;
        rd(5'h06, 16'h0002);
        send <= 1'b0;
        rd(5'h06, 16'h0000);
        rd(5'h06, 16'h000b);
        rd(5'h06, 16'h0009);
        page(16'h7fff, 1'b0);
        i_rst_b <= 1'b0;
        idle(2);
        i_rst_b <= 1'b1;
        idle(1);
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0000);
        idle(2);
        close_out();
    end

    initial
    begin
        #20000;
        miscompares++;
        close_out();
    end
endmodule : lpa_link_partner_ability_tb_top
